// ---- dv/bsfc_checker.sv ----
// port assertions of the boot select and flash control block
`timescale 1ns/1ps
`default_nettype none
module bsfc_checker #(
  parameter PROG_CYCLES = 8
) (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rst_pin_i,
  input wire logic        reset_polarity_i,
  input wire logic        program_store_strap_i,
  input wire logic [7:0]  fuse_i,
  input wire logic        supply_ok_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic        core_run_o,
  input wire logic [15:0] boot_addr_o,
  input wire logic        api_call_o,
  input wire logic        flash_erase_o,
  input wire logic        flash_prog_o
);
  logic        pin_act;
  logic [19:0] prog_cnt_ff;
  assign pin_act = rst_pin_i == reset_polarity_i;
  // length of the running programming phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      prog_cnt_ff <= 20'h00000;
    else
      prog_cnt_ff <= flash_prog_o ? prog_cnt_ff + 20'h00001 : 20'h00000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_release;
    pin_act ##1 !pin_act;
  endsequence
  sequence s_supply_ok;
    supply_ok_i && $past(supply_ok_i) && $past(supply_ok_i, 2);
  endsequence
  a_apb_wait: assert property (psel_i && !penable_i |=> pready_o) else $error("no answer after setup");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_strap_rom: assert property (s_release ##0 !program_store_strap_i |-> ##2 boot_addr_o == 16'hF800)
    else $error("strap low missed rom boot");
  a_fuse_app: assert property (s_release ##0 (program_store_strap_i && fuse_i[6])
    |-> ##2 boot_addr_o == 16'h0000) else $error("fuse one missed application");
  a_boot_held: assert property (!pin_act && !$past(pin_act) && core_run_o |-> $stable(boot_addr_o))
    else $error("boot address moved while running");
  a_decide_first: assert property ($rose(core_run_o) |-> $stable(boot_addr_o))
    else $error("core ran before decision");
  a_api_entry: assert property (core_run_o && fetch_addr_i == 16'hFFF0 |=> api_call_o)
    else $error("service entry missed");
  a_inhibit_stop: assert property (!supply_ok_i ##1 !supply_ok_i |=> !flash_erase_o && !flash_prog_o)
    else $error("flash busy without supply");
  a_erase_prog: assert property ($fell(flash_erase_o) ##0 s_supply_ok |-> ##[0:1] flash_prog_o)
    else $error("no program after erase");
  a_prog_length: assert property ($fell(flash_prog_o) ##0 s_supply_ok |-> prog_cnt_ff == PROG_CYCLES)
    else $error("program phase length");
endmodule // bsfc_checker

bind bsfc_top bsfc_checker #(.PROG_CYCLES(PROG_CYCLES)) i_bsfc_checker (.*);
`default_nettype wire

// ---- dv/bsfc_isp_host.sv ----
// programming host model driving the reset pin and the boot strap pin
`timescale 1ns/1ps
`default_nettype none
module bsfc_isp_host (
  input  wire logic clk_i,
  input  wire logic polarity_i,
  input  wire logic go_i,
  input  wire logic strap_low_i,
  input  wire logic dev_o_i,
  input  wire logic dev_oe_i,
  output logic      rst_pin_o,
  output logic      strap_pin_o,
  output logic      busy_o
);
  logic act = 1'b0;
  logic pull_low = 1'b0;
  initial busy_o = 1'b0;
  assign rst_pin_o = act ? polarity_i : ~polarity_i;
  // pulled up when neither side drives the strap line
  assign strap_pin_o = pull_low ? 1'b0 : (dev_oe_i ? dev_o_i : 1'b1);
  always begin
    @(posedge clk_i);
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      act <= 1'b1;
      pull_low <= strap_low_i;
      repeat (4) @(posedge clk_i);
      act <= 1'b0;
      repeat (2) @(posedge clk_i);
      pull_low <= 1'b0;
      busy_o <= 1'b0;
    end
  end
endmodule // bsfc_isp_host
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking testbench of the boot select and flash control block
`timescale 1ns/1ps
`default_nettype none
`include "bsfc_defs.vh"
module testbench;
  localparam logic [7:0] FWC = `BSFC_OFF_FWC;
  localparam logic [7:0] DWA = `BSFC_OFF_DWADDR;
  localparam logic [7:0] DWD = `BSFC_OFF_DWDATA;
  localparam logic [7:0] STS = `BSFC_OFF_STATUS;
  localparam logic [7:0] UVEC = `BSFC_OFF_SBV;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        reset_polarity_i = 1'b1;
  logic        core_strap_drive_i = 1'b1;
  logic [7:0]  fuse_i = 8'h47;
  logic        supply_ok_i = 1'b1;
  logic [15:0] fetch_addr_i = 16'h0100;
  logic        go = 1'b0;
  logic        slo = 1'b0;
  wire         rst_pin_i, program_store_strap_i, program_store_strap_o, program_store_strap_oe_o, hb;
  wire         pready_o, pslverr_o, core_run_o, api_call_o, double_speed_mode_o, oscillator_select_o;
  wire         expanded_ram_disable_o, flash_erase_o, flash_prog_o;
  wire [31:0]  prdata_o;
  wire [15:0]  boot_addr_o;
  wire [1:0]   lock_level_o;
  wire [10:0]  flash_addr_o;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  bsfc_top #(.INHIBIT_CYCLES(20), .PROG_CYCLES(8)) i_bsfc_top (.*);
  bsfc_isp_host i_bsfc_isp_host (.clk_i(clk_i), .polarity_i(reset_polarity_i), .go_i(go), .strap_low_i(slo),
    .dev_o_i(program_store_strap_o), .dev_oe_i(program_store_strap_oe_o), .rst_pin_o(rst_pin_i),
    .strap_pin_o(program_store_strap_i), .busy_o(hb));
  always #10 clk_i = ~clk_i;
  task automatic close_out;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic pin_rst(input logic low);
    go <= 1'b1;
    slo <= low;
    tk(2);
    go <= 1'b0;
    while (hb) tk(1);
    tk(3);
  endtask
  task automatic t_boot;
    tk(30);
    rdc("control", FWC, 32'h88);
    rdc("shadow", `BSFC_OFF_SHADOW, 32'h57);
    apb(1'b1, `BSFC_OFF_SHADOW, 32'h0);
    rdc("shadow kept", `BSFC_OFF_SHADOW, 32'h57);
    rdc("vector", UVEC, 32'hFC);
    rdc("status byte", `BSFC_OFF_BSB, 32'hFF);
    rdc("status", STS, 32'h2C);
    rdc("unmapped", 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("app start", 32'h0, 32'(boot_addr_o));
    chk("double speed", 32'h1, 32'(double_speed_mode_o));
    chk("oscillator", 32'h1, 32'(oscillator_select_o));
    chk("ram disable", 32'h1, 32'(expanded_ram_disable_o));
    chk("lock default", 32'h0, 32'(lock_level_o));
  endtask
  task automatic t_strap;
    logic [2:0] lb [4] = '{3'b111, 3'b110, 3'b101, 3'b011};
    for (int p = 0; p < 2; p++) begin
      reset_polarity_i <= p[0];
      pin_rst(1'b1);
      chk("rom boot", 32'hF800, 32'(boot_addr_o));
    end
    tk(5);
    chk("strap held", 32'hF800, 32'(boot_addr_o));
    rdc("status rom", STS, 32'h04);
    pin_rst(1'b0);
    chk("app boot", 32'h0, 32'(boot_addr_o));
    fuse_i <= 8'h07;
    apb(1'b1, UVEC, 32'h12);
    pin_rst(1'b0);
    chk("user boot", 32'h1200, 32'(boot_addr_o));
    rdc("status user", STS, 32'h1C);
    rdc("shadow new", `BSFC_OFF_SHADOW, 32'h17);
    apb(1'b1, UVEC, 32'hFC);
    for (int i = 0; i < 4; i++) begin
      fuse_i <= {5'h00, lb[i]};
      pin_rst(1'b0);
      chk("lock level", i, 32'(lock_level_o));
      chk("no user loader", 32'hF800, 32'(boot_addr_o));
    end
  endtask
  task automatic t_flag;
    apb(1'b1, FWC, 32'h10);
    apb(1'b1, DWA, 32'h780);
    chk("flash addr", 32'h780, 32'(flash_addr_o));
    apb(1'b1, DWD, 32'h5A);
    rdc("data", DWD, 32'h5A);
    rdc("flag set", FWC, 32'h98);
    apb(1'b1, DWA, 32'h7FF);
    apb(1'b0, DWD, 32'h0);
    rdc("flag clear", FWC, 32'h18);
    apb(1'b1, FWC, 32'h0);
    rdc("flag off", FWC, 32'h88);
    apb(1'b1, FWC, 32'h10);
    apb(1'b1, DWA, 32'h780);
    apb(1'b0, DWD, 32'h0);
    rdc("flags wiped", FWC, 32'h18);
  endtask
  task automatic run_seq(input logic [31:0] ctl, input int ne);
    int ce = 0;
    int cp = 0;
    apb(1'b1, FWC, ctl);
    // count from the command on, the first phase starts at its completion edge
    fork
      apb(1'b1, `BSFC_OFF_CMD, 32'h1);
      repeat (40) begin
        @(negedge clk_i);
        ce += 32'(flash_erase_o);
        cp += 32'(flash_prog_o);
      end
    join
    @(posedge clk_i);
    chk("erase cycles", 32'(ne), 32'(ce));
    chk("prog cycles", 32'h8, 32'(cp));
  endtask
  task automatic t_inhibit;
    supply_ok_i <= 1'b0;
    tk(3);
    rdc("inhibit low", FWC, 32'h80);
    apb(1'b1, `BSFC_OFF_CMD, 32'h1);
    tk(3);
    chk("refused", 32'h0, 32'({flash_erase_o, flash_prog_o}));
    supply_ok_i <= 1'b1;
    tk(12);
    rdc("inhibit wait", FWC, 32'h80);
    tk(8);
    rdc("inhibit set", FWC, 32'h88);
    apb(1'b1, `BSFC_OFF_CMD, 32'h1);
    tk(3);
    supply_ok_i <= 1'b0;
    tk(3);
    chk("aborted", 32'h0, 32'({flash_erase_o, flash_prog_o}));
    supply_ok_i <= 1'b1;
    core_strap_drive_i <= 1'b0;
    fetch_addr_i <= 16'hFFF0;
    tk(1);
    @(negedge clk_i);
    chk("service entry", 32'h1, 32'(api_call_o));
    chk("strap drive", 32'h2, 32'({program_store_strap_oe_o, program_store_strap_i}));
    @(posedge clk_i);
    fetch_addr_i <= 16'h0100;
    tk(25);
  endtask
  initial begin
    tk(12);
    arst_n_i <= 1'b1;
    t_boot;
    t_strap;
    t_flag;
    run_seq(32'h40, 8);
    run_seq(32'h00, 0);
    t_inhibit;
    close_out;
  end
endmodule // testbench
`default_nettype wire

// ---- rtl/bsfc_defs.vh ----
// constants of the boot select and flash control block
`ifndef BSFC_DEFS_VH
`define BSFC_DEFS_VH
`define BSFC_OFF_FWC      8'h00
`define BSFC_OFF_SHADOW   8'h04
`define BSFC_OFF_SBV      8'h08
`define BSFC_OFF_BSB      8'h0C
`define BSFC_OFF_DWADDR   8'h10
`define BSFC_OFF_DWDATA   8'h14
`define BSFC_OFF_CMD      8'h18
`define BSFC_OFF_STATUS   8'h1C
`define BSFC_FWC_FLAG     7
`define BSFC_FWC_AUTO_ERASE     6
`define BSFC_FWC_MODE     4
`define BSFC_FWC_INH      3
`define BSFC_SH_X2        7
`define BSFC_SH_BOOT_JUMP_FUSE      6
`define BSFC_SH_OSC       5
`define BSFC_SH_RSVD      4
`define BSFC_SH_EXPANDED_RAM_DISABLE      3
`define BSFC_SHADOW_RST   8'hB8
`define BSFC_SBV_RST      8'hFC
`define BSFC_BSB_RST      8'hFF
`define BSFC_FLAG_LO      11'h780
`define BSFC_FLAG_HI      11'h7FF
`define BSFC_ROM_BOOT     16'hF800
`define BSFC_APP_BOOT     16'h0000
`define BSFC_API_ENTRY    16'hFFF0
`define BSFC_CLK_MHZ      50
`define BSFC_INHIBIT_MS   2
`define BSFC_PROG_MS      10
`define BSFC_BOOT_ROM     2'h0
`define BSFC_BOOT_USER    2'h1
`define BSFC_BOOT_APP     2'h2
`endif

// ---- rtl/bsfc_top.v ----
// boot source selection, shadow fuse byte and flash write control with apb registers
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bsfc_defs.vh"

// How it works
// - with flag mode on, window reads at 780h-7FFh load that location's flag into readback.
// - with flag mode off, the flag readback bit reads one.
// - auto-erase set makes the next write sequence erase the page first.
// - with flag mode on, window writes at 780h-7FFh set that location's flag.
// - flag mode off holds all byte flags at zero.
// - inhibit clears at once on low supply, sets after 2 ms good supply.
// - fetches at FFF0h are flagged as the common rom service entry.
// - strap low at the reset release edge of either polarity selects rom bootloader.
// - strap is sampled only at reset release; later pin changes are ignored.
// - strap condition wins over jump fuse and user vector; the status byte takes no part in the boot choice.
// - without strap, jump fuse zero selects bootloader, one selects application.
// - the boot choice is made in hardware before the core is let run.
// - user vector gives high byte of user loader; FCh means none.
// - the shadow byte mirrors the fuse and security bits for reading.
// - shadow bit 7 zero gives double speed, one gives standard speed.
// - shadow bit 6 one starts application at 0000h, zero the loader at F800h, or the user loader when the user vector is not FCh.
// - shadow bit 5 zero selects oscillator B, one oscillator A.
// - shadow bit 3 zero disables expanded ram, one enables it.
// - shadow bits 2-0 are lock bits that software cannot change.
// - lock bits decode to four protection levels, default most restrictive.
module bsfc_top #(
  parameter INHIBIT_CYCLES = `BSFC_INHIBIT_MS * 1000 * `BSFC_CLK_MHZ,
  parameter PROG_CYCLES    = `BSFC_PROG_MS * 1000 * `BSFC_CLK_MHZ
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        rst_pin_i,
  input  wire        reset_polarity_i,
  input  wire        program_store_strap_i,
  output wire        program_store_strap_o,
  output wire        program_store_strap_oe_o,
  input  wire        core_strap_drive_i,
  input  wire [7:0]  fuse_i,
  input  wire        supply_ok_i,
  input  wire [15:0] fetch_addr_i,
  output wire        core_run_o,
  output wire [15:0] boot_addr_o,
  output wire        api_call_o,
  output wire        double_speed_mode_o,
  output wire        oscillator_select_o,
  output wire        expanded_ram_disable_o,
  output wire [1:0]  lock_level_o,
  output wire        flash_erase_o,
  output wire        flash_prog_o,
  output wire [10:0] flash_addr_o
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_ERASE = 2'd1;
  localparam ST_PROG  = 2'd2;

  reg  [7:0]   mem [0:2047];
  reg  [127:0] flags_ff;
  reg          flag_rb_ff;
  reg          auto_erase_ff;
  reg          mode_ff;
  reg          inhibit_ff;
  reg  [16:0]  inh_cnt_ff;
  reg  [7:0]   shadow_ff;
  reg  [7:0]   sbv_ff;
  reg  [7:0]   bsb_ff;
  reg  [10:0]  dwaddr_ff;
  reg  [1:0]   state_ff;
  reg  [18:0]  tmr_ff;
  reg          pin_act_ff;
  reg          strap_ff;
  reg  [1:0]   boot_kind_ff;
  reg  [15:0]  boot_addr_ff;
  reg          core_run_ff;
  reg          api_call_ff;
  reg  [31:0]  prdata_ff;
  reg          pready_ff;
  reg          pslverr_ff;
  reg          erase_ff;
  reg          prog_ff;
  reg  [1:0]   lock_ff;
  reg          dsm_ff;
  reg          osc_ff;
  reg          expanded_ram_disable_dis_ff;
  reg  [7:0]   nxt_shadow;
  reg  [1:0]   nxt_kind;
  reg  [15:0]  nxt_boot;
  reg  [31:0]  nxt_rdata;
  reg          nxt_err;
  reg  [1:0]   nxt_lock;

  wire         setup    = psel_i & ~penable_i;
  wire         done     = psel_i & penable_i & pready_ff;
  wire         wr_done  = done & pwrite_i & ~pslverr_ff;
  wire         rd_done  = done & ~pwrite_i & ~pslverr_ff;
  wire         in_flag  = (dwaddr_ff >= `BSFC_FLAG_LO) && (dwaddr_ff <= `BSFC_FLAG_HI);
  wire [6:0]   flag_idx = dwaddr_ff[6:0];
  wire         pin_act  = (rst_pin_i == reset_polarity_i);
  // a pin release in either polarity starts the boot capture
  wire         pin_rel  = pin_act_ff & ~pin_act;
  wire         win_wr   = wr_done && (paddr_i == `BSFC_OFF_DWDATA);
  wire         win_rd   = rd_done && (paddr_i == `BSFC_OFF_DWDATA);
  wire         start    = wr_done && (paddr_i == `BSFC_OFF_CMD) && pwdata_i[0] && inhibit_ff && (state_ff == ST_IDLE);
  wire [7:0]   fwc_rd   = {flag_rb_ff, auto_erase_ff, 1'b0, mode_ff, inhibit_ff, 3'b000};

  // shadow image taken from the fuses, reserved bit forced
  always @* begin
    nxt_shadow = fuse_i;
    nxt_shadow[`BSFC_SH_RSVD] = 1'b1;
  end

  // boot source decision from strap, fuse and user vector
  always @* begin
    nxt_kind = `BSFC_BOOT_ROM;
    nxt_boot = `BSFC_ROM_BOOT;
    if (!program_store_strap_i) begin
      nxt_kind = `BSFC_BOOT_ROM;
      nxt_boot = `BSFC_ROM_BOOT;
    end else if (nxt_shadow[`BSFC_SH_BOOT_JUMP_FUSE]) begin
      nxt_kind = `BSFC_BOOT_APP;
      nxt_boot = `BSFC_APP_BOOT;
    end else if (sbv_ff != `BSFC_SBV_RST) begin
      nxt_kind = `BSFC_BOOT_USER;
      nxt_boot = {sbv_ff, 8'h00};
    end
  end

  // lock bits to protection level minus one
  always @* begin
    if (!shadow_ff[2]) begin
      nxt_lock = 2'd3;
    end else if (!shadow_ff[1]) begin
      nxt_lock = 2'd2;
    end else if (!shadow_ff[0]) begin
      nxt_lock = 2'd1;
    end else begin
      nxt_lock = 2'd0;
    end
  end

  // read mux, evaluated in the setup cycle
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    case (paddr_i)
      `BSFC_OFF_FWC:    nxt_rdata[7:0] = fwc_rd;
      `BSFC_OFF_SHADOW: nxt_rdata[7:0] = shadow_ff;
      `BSFC_OFF_SBV:    nxt_rdata[7:0] = sbv_ff;
      `BSFC_OFF_BSB:    nxt_rdata[7:0] = bsb_ff;
      `BSFC_OFF_DWADDR: nxt_rdata[10:0] = dwaddr_ff;
      `BSFC_OFF_DWDATA: nxt_rdata[7:0] = mem[dwaddr_ff];
      `BSFC_OFF_CMD:    nxt_rdata = 32'h0000_0000;
      `BSFC_OFF_STATUS: nxt_rdata[7:0] = {2'b00, boot_kind_ff, strap_ff, core_run_ff,
                                          state_ff == ST_ERASE, state_ff != ST_IDLE};
      default:          nxt_err = 1'b1;
    endcase
  end

  // apb handshake: no wait states, data and ready from flops
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= pwrite_i ? 32'h0000_0000 : nxt_rdata;
      pready_ff  <= 1'b1;
      pslverr_ff <= nxt_err;
    end else if (done) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // software registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      auto_erase_ff   <= 1'b0;
      mode_ff   <= 1'b0;
      sbv_ff    <= `BSFC_SBV_RST;
      bsb_ff    <= `BSFC_BSB_RST;
      dwaddr_ff <= 11'h000;
    end else if (wr_done) begin
      case (paddr_i)
        `BSFC_OFF_FWC: begin
          auto_erase_ff <= pwdata_i[`BSFC_FWC_AUTO_ERASE];
          mode_ff <= pwdata_i[`BSFC_FWC_MODE];
        end
        `BSFC_OFF_SBV:    sbv_ff    <= pwdata_i[7:0];
        `BSFC_OFF_BSB:    bsb_ff    <= pwdata_i[7:0];
        `BSFC_OFF_DWADDR: dwaddr_ff <= pwdata_i[10:0];
        default: begin
        end
      endcase
    end
  end

  // data window storage
  always @(posedge clk_i) begin
    if (win_wr) begin
      mem[dwaddr_ff] <= pwdata_i[7:0];
    end
  end

  // byte flags and their readback
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags_ff   <= 128'd0;
      flag_rb_ff <= 1'b1;
    end else if (!mode_ff) begin
      flags_ff   <= 128'd0;
      flag_rb_ff <= 1'b1;
    end else begin
      if (win_wr && in_flag) begin
        flags_ff[flag_idx] <= 1'b1;
      end
      if (win_rd && in_flag) begin
        flag_rb_ff <= flags_ff[flag_idx];
      end
    end
  end

  // write inhibit qualified by supply good time
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inhibit_ff <= 1'b0;
      inh_cnt_ff <= 17'd0;
    end else if (!supply_ok_i) begin
      inhibit_ff <= 1'b0;
      inh_cnt_ff <= 17'd0;
    end else if (inh_cnt_ff >= INHIBIT_CYCLES[16:0] - 17'd1) begin
      inhibit_ff <= 1'b1;
    end else begin
      inh_cnt_ff <= inh_cnt_ff + 17'd1;
    end
  end

  // flash write sequence: optional erase then program
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_IDLE;
      tmr_ff   <= 19'd0;
      erase_ff <= 1'b0;
      prog_ff  <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          tmr_ff <= 19'd0;
          if (start) begin
            state_ff <= auto_erase_ff ? ST_ERASE : ST_PROG;
            erase_ff <= auto_erase_ff;
            prog_ff  <= ~auto_erase_ff;
          end
        end
        ST_ERASE: begin
          if (!inhibit_ff || tmr_ff >= PROG_CYCLES[18:0] - 19'd1) begin
            state_ff <= inhibit_ff ? ST_PROG : ST_IDLE;
            tmr_ff   <= 19'd0;
            erase_ff <= 1'b0;
            prog_ff  <= inhibit_ff;
          end else begin
            tmr_ff <= tmr_ff + 19'd1;
          end
        end
        ST_PROG: begin
          if (!inhibit_ff || tmr_ff >= PROG_CYCLES[18:0] - 19'd1) begin
            state_ff <= ST_IDLE;
            tmr_ff   <= 19'd0;
            prog_ff  <= 1'b0;
          end else begin
            tmr_ff <= tmr_ff + 19'd1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          erase_ff <= 1'b0;
          prog_ff  <= 1'b0;
        end
      endcase
    end
  end

  // boot capture at the reset pin release, core held until decided
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_act_ff   <= 1'b1;
      strap_ff     <= 1'b1;
      shadow_ff    <= `BSFC_SHADOW_RST;
      boot_kind_ff <= `BSFC_BOOT_ROM;
      boot_addr_ff <= `BSFC_ROM_BOOT;
      core_run_ff  <= 1'b0;
      lock_ff      <= 2'd3;
    end else begin
      pin_act_ff <= pin_act;
      lock_ff    <= nxt_lock;
      if (pin_act) begin
        core_run_ff <= 1'b0;
      end else if (pin_rel) begin
        strap_ff     <= program_store_strap_i;
        shadow_ff    <= nxt_shadow;
        boot_kind_ff <= nxt_kind;
        boot_addr_ff <= nxt_boot;
      end else begin
        core_run_ff <= 1'b1;
      end
    end
  end

  // clock, oscillator and ram selections held in flops of their own
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dsm_ff      <= 1'b0;
      osc_ff      <= 1'b0;
      expanded_ram_disable_dis_ff <= 1'b0;
    end else if (pin_rel) begin
      dsm_ff      <= ~nxt_shadow[`BSFC_SH_X2];
      osc_ff      <= ~nxt_shadow[`BSFC_SH_OSC];
      expanded_ram_disable_dis_ff <= ~nxt_shadow[`BSFC_SH_EXPANDED_RAM_DISABLE];
    end
  end

  // rom service entry detection
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      api_call_ff <= 1'b0;
    end else begin
      api_call_ff <= core_run_ff && (fetch_addr_i == `BSFC_API_ENTRY);
    end
  end

  // strap pin driven by the core only while it runs
  reg strap_oe_ff;
  reg strap_out_ff;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_oe_ff  <= 1'b0;
      strap_out_ff <= 1'b1;
    end else begin
      strap_oe_ff  <= core_run_ff & ~pin_act;
      strap_out_ff <= core_strap_drive_i;
    end
  end

  assign prdata_o                 = prdata_ff;
  assign pready_o                 = pready_ff;
  assign pslverr_o                = pslverr_ff;
  assign program_store_strap_o    = strap_out_ff;
  assign program_store_strap_oe_o = strap_oe_ff;
  assign core_run_o               = core_run_ff;
  assign boot_addr_o              = boot_addr_ff;
  assign api_call_o               = api_call_ff;
  assign double_speed_mode_o      = dsm_ff;
  assign oscillator_select_o      = osc_ff;
  assign expanded_ram_disable_o   = expanded_ram_disable_dis_ff;
  assign lock_level_o             = lock_ff;
  assign flash_erase_o            = erase_ff;
  assign flash_prog_o             = prog_ff;
  assign flash_addr_o             = dwaddr_ff;

endmodule // bsfc_top
`default_nettype wire
